// ### include/srq_pkg.sv
/*
  Package for the sink send-request task block: register indices and byte
  addresses, field positions, reset values, result codes and carrier structs.
  Assumes a 40 MHz bus clock and word-aligned AHB-Lite register access.
*/
package srq_pkg;

  // ****************************************************************
  // Register map (index, byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_TASK_CMD = 8'h08;
  localparam logic [7:0] IDX_TASK_DATA = 8'h09;
  localparam logic [7:0] IDX_INT_STATUS = 8'h14;
  localparam logic [7:0] IDX_INT_ENABLE = 8'h16;
  localparam logic [7:0] IDX_INT_CLEAR = 8'h18;
  localparam logic [7:0] IDX_SYS_CONFIG = 8'h28;
  localparam logic [7:0] IDX_ACT_PDO = 8'h34;
  localparam logic [7:0] IDX_ACT_RDO = 8'h35;
  localparam logic [7:0] IDX_SINK_REQ = 8'h36;

  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_TASK_CMD = {2'b00, IDX_TASK_CMD, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TASK_DATA = {2'b00, IDX_TASK_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = {2'b00, IDX_INT_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = {2'b00, IDX_INT_ENABLE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INT_CLEAR = {2'b00, IDX_INT_CLEAR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SYS_CONFIG = {2'b00, IDX_SYS_CONFIG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ACT_PDO = {2'b00, IDX_ACT_PDO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ACT_RDO = {2'b00, IDX_ACT_RDO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SINK_REQ = {2'b00, IDX_SINK_REQ, 2'b00};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RDO_COMMS_BIT = 25;
  localparam int RDO_NO_SUSP_BIT = 24;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_BUSY_BIT = 8;
  localparam int CFG_SINK_ROLE_BIT = 0;
  localparam int CFG_HOST_MODE_BIT = 1;
  localparam int CFG_COMMS_BIT = 2;
  localparam int CFG_SUSP_LSB = 4;
  localparam int INT_CONTRACT_BIT = 0;
  localparam int INT_TASK_DONE_BIT = 1;
  localparam int INT_W = 2;

  // ****************************************************************
  // Reset values and result codes
  // ****************************************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [5:0] RST_CFG = 6'h00;
  localparam logic [7:0] RES_SUCCESS = 8'h00;
  localparam logic [7:0] RES_TIMEOUT = 8'h01;
  localparam logic [7:0] RES_REJECTED = 8'h03;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_HOST_WINDOW_NS = 10_000;
  localparam int HOST_WINDOW_CYC = T_HOST_WINDOW_NS / CLK_PERIOD_NS;
  localparam int WIN_W = 10;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic src_caps;
    logic caps_suspend_ok;
    logic accept;
    logic reject;
    logic ps_rdy;
    logic port_event;
    logic neg_timeout;
    logic tx_done;
  } srq_pd_rx_t;

  typedef struct packed {
    logic [1:0] suspend_sink_policy;
    logic comms_capable_flag;
    logic sink_host_controlled_mode;
    logic sink_role;
  } srq_cfg_t;

endpackage

// ### core/srq_task.sv
/*
  Sink send-request task engine with its AHB-Lite register slave, the
  interrupt status, enable and clear registers, and the automatic request
  path used when the host is late.
  Assumes a protocol layer that reports received messages and timer expiry
  as one-cycle pulses and takes a request when tx_ready is high.
*/
// Register access over AHB-Lite was decided locally.
// Functional notes
// - Any negotiation timeout before source ready ends the task as timed out.
// - Fresh source capabilities while the task pends end it as timed out.
// - Disconnect, soft or hard reset before completion ends it as timed out.
// - Fixed bits 25:24, then match with stored sink request means success.
// - A matching request object sends no request message.
// - Request sent, then accept and source ready, means success.
// - Task ends at source ready, rejection or timeout, immediately.
// - Suspend policy 11b does not hold off task completion.
// - Caps with suspend support cleared start another negotiation in host mode; the code never reads caps_suspend_ok.
// - Sink request register is written on input, bits 25:24 already fixed.
// - New contract updates active PDO and RDO and raises contract event.
// - Matching request raises the contract event at once.
// - Host late after new caps: device sends its own automatic request.
// - A late task sends its request at the first opportunity.
// - Bit 25 comes from the comms capable configuration field.
// - Bit 24 comes from the suspend sink policy configuration field.
// - Reject when not sink or host-controlled mode is off.
// - Reject when the source answers the request with reject.
`timescale 1ns/1ps
`default_nettype none

module srq_task
  import srq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire srq_pd_rx_t pd_rx,
  input wire logic [31:0] auto_rdo,
  input wire logic [31:0] contract_pdo,
  input wire logic tx_ready,
  output logic tx_req_valid,
  output logic [31:0] tx_req_rdo
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  typedef enum {
    ST_IDLE,
    ST_CHECK,
    ST_SEND,
    ST_WAIT_TX,
    ST_WAIT_ACCEPT,
    ST_WAIT_READY
  } srq_state_t;

  srq_state_t state_q;
  logic wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] task_data_q;
  logic [31:0] sink_req_q;
  logic [31:0] act_pdo_q;
  logic [31:0] act_rdo_q;
  logic [5:0] cfg_q;
  logic [7:0] result_q;
  logic [INT_W-1:0] int_stat_q;
  logic [INT_W-1:0] int_en_q;
  logic irq_q;
  logic tx_valid_q;
  logic [31:0] tx_rdo_q;
  logic auto_busy_q;
  logic auto_arm_q;
  logic [WIN_W-1:0] win_cnt_q;
  logic go_wr;
  logic int_clr_wr;
  logic addr_valid;
  logic [31:0] rd_word;
  logic [31:0] fixed_rdo;
  logic task_busy;
  logic contract_evt;
  logic done_evt;
  logic task_abort;
  logic auto_send;
  srq_cfg_t cfg;

  // Bit 3 is a spare, so fields are picked by position, not by a plain cast
  assign cfg = srq_cfg_t'({cfg_q[CFG_SUSP_LSB +: 2], cfg_q[CFG_COMMS_BIT],
    cfg_q[CFG_HOST_MODE_BIT], cfg_q[CFG_SINK_ROLE_BIT]});
  assign task_busy = (state_q != ST_IDLE);
  assign addr_valid = hsel & hready & htrans[1];
  assign go_wr = wr_pend_q & (wr_addr_q == ADDR_TASK_CMD) & hwdata[CMD_GO_BIT];
  assign int_clr_wr = wr_pend_q & (wr_addr_q == ADDR_INT_CLEAR);

  always_comb begin
    case (haddr[ADDR_W-1:0])
      ADDR_TASK_CMD: rd_word = {16'h0000, 7'h00, task_busy, result_q};
      ADDR_TASK_DATA: rd_word = task_data_q;
      ADDR_INT_STATUS: rd_word = {{(32-INT_W){1'b0}}, int_stat_q};
      ADDR_INT_ENABLE: rd_word = {{(32-INT_W){1'b0}}, int_en_q};
      ADDR_SYS_CONFIG: rd_word = {26'h000_0000, cfg_q};
      ADDR_ACT_PDO: rd_word = act_pdo_q;
      ADDR_ACT_RDO: rd_word = act_rdo_q;
      ADDR_SINK_REQ: rd_word = sink_req_q;
      default: rd_word = RST_WORD;
    endcase
  end

  // Zero wait states: read data is latched at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= RST_WORD;
    end else begin
      wr_pend_q <= addr_valid & hwrite;
      if (addr_valid) begin
        wr_addr_q <= haddr[ADDR_W-1:0];
      end
      if (addr_valid & !hwrite) begin
        hrdata_q <= rd_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      task_data_q <= RST_WORD;
      cfg_q <= RST_CFG;
      int_en_q <= '0;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        ADDR_TASK_DATA: task_data_q <= hwdata;
        ADDR_SYS_CONFIG: cfg_q <= hwdata[5:0];
        ADDR_INT_ENABLE: int_en_q <= hwdata[INT_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Request object fix-up
  // ****************************************************************
  always_comb begin
    fixed_rdo = task_data_q;
    fixed_rdo[RDO_COMMS_BIT] = cfg.comms_capable_flag;
    fixed_rdo[RDO_NO_SUSP_BIT] = (cfg.suspend_sink_policy != 2'b00);
  end

  // Any of these ends a pending task as timed out
  assign task_abort = pd_rx.neg_timeout
    | pd_rx.src_caps
    | pd_rx.port_event;

  // ****************************************************************
  // Task state machine
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      result_q <= RES_SUCCESS;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go_wr) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (!cfg.sink_role || !cfg.sink_host_controlled_mode) begin
            result_q <= RES_REJECTED;
            state_q <= ST_IDLE;
          end else if (fixed_rdo == sink_req_q) begin
            result_q <= RES_SUCCESS;
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (task_abort) begin
            result_q <= RES_TIMEOUT;
            state_q <= ST_IDLE;
          end else if (!auto_busy_q && tx_ready && !tx_valid_q) begin
            state_q <= ST_WAIT_TX;
          end
        end
        ST_WAIT_TX: begin
          if (task_abort) begin
            result_q <= RES_TIMEOUT;
            state_q <= ST_IDLE;
          end else if (pd_rx.tx_done) begin
            state_q <= ST_WAIT_ACCEPT;
          end
        end
        ST_WAIT_ACCEPT: begin
          if (task_abort) begin
            result_q <= RES_TIMEOUT;
            state_q <= ST_IDLE;
          end else if (pd_rx.reject) begin
            result_q <= RES_REJECTED;
            state_q <= ST_IDLE;
          end else if (pd_rx.accept) begin
            state_q <= ST_WAIT_READY;
          end
        end
        ST_WAIT_READY: begin
          if (pd_rx.ps_rdy) begin
            result_q <= RES_SUCCESS;
            state_q <= ST_IDLE;
          end else if (task_abort) begin
            result_q <= RES_TIMEOUT;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Sink request and active contract registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sink_req_q <= RST_WORD;
    end else if (state_q == ST_CHECK && cfg.sink_role && cfg.sink_host_controlled_mode) begin
      sink_req_q <= fixed_rdo;
    end else if (wr_pend_q && wr_addr_q == ADDR_SINK_REQ) begin
      sink_req_q <= hwdata;
    end
  end

  // Contract lands on source ready for either the task or the auto request
  assign contract_evt = pd_rx.ps_rdy & ((state_q == ST_WAIT_READY) | auto_busy_q)
    | (state_q == ST_CHECK) & cfg.sink_role & cfg.sink_host_controlled_mode
      & (fixed_rdo == sink_req_q);
  assign done_evt = task_busy & (state_q != ST_CHECK) & (state_q != ST_IDLE)
    & (pd_rx.ps_rdy & (state_q == ST_WAIT_READY) | task_abort
      | pd_rx.reject & (state_q == ST_WAIT_ACCEPT))
    | (state_q == ST_CHECK) & (!cfg.sink_role | !cfg.sink_host_controlled_mode
      | (fixed_rdo == sink_req_q));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_pdo_q <= RST_WORD;
      act_rdo_q <= RST_WORD;
    end else if (pd_rx.ps_rdy && (state_q == ST_WAIT_READY || auto_busy_q)) begin
      act_pdo_q <= contract_pdo;
      act_rdo_q <= tx_rdo_q;
    end
  end

  // ****************************************************************
  // Automatic request when the host is late
  // ****************************************************************
  assign auto_send = auto_arm_q & (win_cnt_q == '0) & !task_busy & tx_ready & !tx_valid_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_arm_q <= 1'b0;
      win_cnt_q <= '0;
    end else if (pd_rx.src_caps && cfg.sink_role && cfg.sink_host_controlled_mode) begin
      auto_arm_q <= 1'b1;
      win_cnt_q <= WIN_W'(HOST_WINDOW_CYC - 1);
    end else if (go_wr || pd_rx.port_event || auto_send) begin
      auto_arm_q <= 1'b0;
    end else if (auto_arm_q && win_cnt_q != '0) begin
      win_cnt_q <= win_cnt_q - WIN_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_busy_q <= 1'b0;
    end else if (auto_send) begin
      auto_busy_q <= 1'b1;
    end else if (pd_rx.ps_rdy || pd_rx.reject || pd_rx.neg_timeout || pd_rx.port_event) begin
      auto_busy_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Request transmit handshake
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_valid_q <= 1'b0;
      tx_rdo_q <= RST_WORD;
    end else if (state_q == ST_SEND && !task_abort && !auto_busy_q && tx_ready && !tx_valid_q) begin
      tx_valid_q <= 1'b1;
      tx_rdo_q <= sink_req_q;
    end else if (auto_send) begin
      tx_valid_q <= 1'b1;
      tx_rdo_q <= auto_rdo;
    end else if (tx_valid_q && tx_ready) begin
      tx_valid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // Set wins over a clear landing in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      int_stat_q[INT_CONTRACT_BIT] <= contract_evt
        | int_stat_q[INT_CONTRACT_BIT] & !(int_clr_wr & hwdata[INT_CONTRACT_BIT]);
      int_stat_q[INT_TASK_DONE_BIT] <= done_evt
        | int_stat_q[INT_TASK_DONE_BIT] & !(int_clr_wr & hwdata[INT_TASK_DONE_BIT]);
      irq_q <= |(int_stat_q & int_en_q);
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_q;
  assign tx_req_valid = tx_valid_q;
  assign tx_req_rdo = tx_rdo_q;

endmodule // srq_task

`default_nettype wire

// ### test/srq_task_properties.sv
/*
  Port checker for the send-request task block.
  Assumes it is bound to srq_task and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module srq_task_properties
  import srq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic irq,
  input wire srq_pd_rx_t pd_rx,
  input wire logic tx_ready,
  input wire logic tx_req_valid,
  input wire logic [31:0] tx_req_rdo
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  logic wr_ap_q;
  logic rd_ap;
  logic rd_far;
  logic ev;
  assign rd_ap = hsel && hready && htrans[1] && !hwrite;
  // Every mapped word sits below 0x100
  assign rd_far = rd_ap && (haddr[11:8] != 4'h0);
  assign ev = (pd_rx != 8'h00);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ap_q <= 1'b0;
    end else begin
      wr_ap_q <= hsel && hready && htrans[1] && hwrite;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_tx_held: assert property (tx_req_valid && !tx_ready |=> tx_req_valid && $stable(tx_req_rdo))
    else $error("request changed before taken");
  a_tx_once: assert property (tx_req_valid && tx_ready |=> !tx_req_valid)
    else $error("request offered twice");
  a_tx_ready: assert property ($rose(tx_req_valid) |-> $past(tx_ready))
    else $error("request raised while far side busy");
  a_reset_quiet: assert property ($rose(hresetn) |-> !irq && !tx_req_valid)
    else $error("outputs active after reset");
  a_rd_hold: assert property (!rd_ap |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_far_zero: assert property (rd_far |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_irq_fall: assert property ($fell(irq) |-> $past(wr_ap_q, 1) || $past(wr_ap_q, 2)
    || $past(wr_ap_q, 3)) else $error("interrupt dropped without a write");
  a_irq_rise: assert property ($rose(irq) |-> $past(wr_ap_q, 2) || $past(wr_ap_q, 3)
    || $past(wr_ap_q, 4) || $past(ev, 1) || $past(ev, 2) || $past(ev, 3))
    else $error("interrupt raised without a cause");
  c_stall: cover property (tx_req_valid && !tx_ready);
  c_irq: cover property ($rose(irq));
  c_far: cover property (rd_far);
endmodule // srq_task_properties
bind srq_task srq_task_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .irq(irq), .pd_rx(pd_rx), .tx_ready(tx_ready), .tx_req_valid(tx_req_valid),
  .tx_req_rdo(tx_req_rdo));
`default_nettype wire

// ### test/srq_source_model.sv
/*
  Source-side model: takes requests and answers with transmit done,
  accept or reject, then source ready.
  Assumes one request at a time; the bench sets mode and injects events.
*/
`timescale 1ns/1ps
`default_nettype none
module srq_source_model
  import srq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_req_valid,
  input wire logic [31:0] tx_req_rdo,
  input wire logic [1:0] mode,
  input wire logic [7:0] inj,
  output var srq_pd_rx_t pd_rx,
  output logic tx_ready,
  output logic [31:0] last_rdo,
  output logic [7:0] n_req
);
  // ****************************************************************
  // Message sequencer
  // ****************************************************************
  logic [1:0] ph_q;
  logic [5:0] cnt_q;
  logic [1:0] dly_q;
  logic [7:0] seq_q;
  // Slow mode stalls a raised request three cycles
  assign tx_ready = (ph_q == 2'h0) && !(mode == 2'h3 && tx_req_valid && dly_q != 2'h3);
  assign pd_rx = srq_pd_rx_t'(seq_q | inj);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 2'h0;
      cnt_q <= 6'h00;
      dly_q <= 2'h0;
      seq_q <= 8'h00;
      last_rdo <= 32'h0000_0000;
      n_req <= 8'h00;
    end else begin
      seq_q <= 8'h00;
      dly_q <= !tx_req_valid ? 2'h0 : (dly_q == 2'h3 ? dly_q : dly_q + 2'h1);
      if (tx_req_valid && tx_ready) begin
        ph_q <= 2'h1;
        cnt_q <= 6'h02;
        n_req <= n_req + 8'h01;
        last_rdo <= tx_req_rdo;
      end else if (ph_q != 2'h0 && cnt_q != 6'h00) begin
        cnt_q <= cnt_q - 6'h01;
      end else if (ph_q == 2'h1) begin
        seq_q <= 8'h01;
        ph_q <= (mode == 2'h2) ? 2'h0 : 2'h2;
        cnt_q <= (mode == 2'h3) ? 6'h28 : 6'h04;
      end else if (ph_q == 2'h2) begin
        seq_q <= (mode == 2'h1) ? 8'h10 : 8'h20;
        ph_q <= (mode == 2'h1) ? 2'h0 : 2'h3;
        cnt_q <= 6'h04;
      end else if (ph_q == 2'h3) begin
        seq_q <= 8'h08;
        ph_q <= 2'h0;
      end
    end
  end
endmodule // srq_source_model
`default_nettype wire

// ### test/tb.sv
/*
  Bench for the send-request task block: bus tasks, reset and unmapped cases,
  a table of task cases, then automatic-request and second-reset cases.
  Assumes the source model drives the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import srq_pkg::*;
;
  typedef struct packed {
    logic [5:0] cfg;
    logic [31:0] rdo;
    logic [1:0] m;
    logic [7:0] ev;
    logic [7:0] res;
    logic req;
  } srq_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, tx_ready, tx_req_valid;
  logic [31:0] haddr, hwdata, hrdata, rd, exp, tx_req_rdo, last_rdo;
  logic [1:0] htrans, mode;
  logic [2:0] hsize;
  logic [7:0] n_req, n0, inj;
  srq_pd_rx_t pd_rx;
  logic [31:0] auto_rdo = 32'h0A0B_0C0D;
  logic [31:0] contract_pdo = 32'hC0DE_0001;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int k;
  logic [11:0] rst_map [6] = '{ADDR_TASK_CMD, ADDR_INT_STATUS, ADDR_ACT_PDO, ADDR_ACT_RDO,
    ADDR_SINK_REQ, 12'h3FC};
  srq_row_t rows [8] = '{
    '{6'h0B, 32'h1234_5678, 2'h0, 8'h00, RES_SUCCESS, 1'h1},
    '{6'h37, 32'h0000_0001, 2'h3, 8'h00, RES_SUCCESS, 1'h1},
    '{6'h37, 32'h0000_0001, 2'h0, 8'h00, RES_SUCCESS, 1'h0},
    '{6'h13, 32'h0000_0001, 2'h1, 8'h00, RES_REJECTED, 1'h1},
    '{6'h01, 32'h0000_0005, 2'h0, 8'h00, RES_REJECTED, 1'h0},
    '{6'h02, 32'h0000_0005, 2'h0, 8'h00, RES_REJECTED, 1'h0},
    '{6'h03, 32'h0000_0022, 2'h2, 8'h02, RES_TIMEOUT, 1'h1},
    '{6'h03, 32'h0000_0033, 2'h2, 8'h04, RES_TIMEOUT, 1'h1}};
  srq_task uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .pd_rx(pd_rx), .auto_rdo(auto_rdo),
    .contract_pdo(contract_pdo), .tx_ready(tx_ready), .tx_req_valid(tx_req_valid),
    .tx_req_rdo(tx_req_rdo));
  srq_source_model src (.hclk(hclk), .hresetn(hresetn), .tx_req_valid(tx_req_valid),
    .tx_req_rdo(tx_req_rdo), .mode(mode), .inj(inj), .pd_rx(pd_rx), .tx_ready(tx_ready),
    .last_rdo(last_rdo), .n_req(n_req));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic run(input srq_row_t r);
    ahb(1'b1, ADDR_SYS_CONFIG, 32'(r.cfg));
    ahb(1'b1, ADDR_TASK_DATA, r.rdo);
    mode <= r.m;
    n0 = n_req;
    ahb(1'b1, ADDR_TASK_CMD, 32'h0000_0001);
    if (r.ev != 8'h00) begin
      repeat (30) @(posedge hclk);
      inj <= r.ev;
      @(posedge hclk);
      inj <= 8'h00;
    end
    k = 0;
    do begin
      ahb(1'b0, ADDR_TASK_CMD, 32'h0000_0000);
      k++;
    end while (rd[8] !== 1'b0 && k < 200);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************************************
  // Clock, timeout and sequence
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Ceiling well above the roughly 900 cycles the run needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, inj, mode} = '0;
    hsize = 3'h2;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rst_map[i]) begin
      ahb(1'b0, rst_map[i], 32'h0000_0000);
      check("reset_value", rd, 32'h0000_0000);
    end
    ahb(1'b1, ADDR_ACT_PDO, 32'hFFFF_FFFF);
    ahb(1'b0, ADDR_ACT_PDO, 32'h0000_0000);
    check("act_pdo_ro", rd, 32'h0000_0000);
    ahb(1'b1, ADDR_SINK_REQ, 32'h0000_00AA);
    ahb(1'b0, ADDR_SINK_REQ, 32'h0000_0000);
    check("sink_req_rw", rd, 32'h0000_00AA);
    check("bus_okay", 32'({hresp, hreadyout}), 32'h0000_0001);
    ahb(1'b1, ADDR_INT_ENABLE, 32'h0000_0001);
    $display("test reset done");
    foreach (rows[i]) begin
      run(rows[i]);
      check("result", 32'(rd[7:0]), 32'(rows[i].res));
      check("requests", 32'(n_req - n0), 32'(rows[i].req));
      exp = {rows[i].rdo[31:26], rows[i].cfg[2], rows[i].cfg[5:4] != 2'h0, rows[i].rdo[23:0]};
      if (rows[i].res === RES_SUCCESS) begin
        ahb(1'b0, ADDR_SINK_REQ, 32'h0000_0000);
        check("sink_req", rd, exp);
        check("sent_rdo", last_rdo, exp);
        ahb(1'b0, ADDR_ACT_RDO, 32'h0000_0000);
        check("act_rdo", rd, exp);
        ahb(1'b0, ADDR_ACT_PDO, 32'h0000_0000);
        check("act_pdo", rd, contract_pdo);
      end
      check("irq", 32'(irq), 32'(rows[i].res === RES_SUCCESS));
      ahb(1'b1, ADDR_INT_CLEAR, 32'h0000_0003);
      ahb(1'b0, ADDR_INT_STATUS, 32'h0000_0000);
      check("int_clear", rd, 32'h0000_0000);
      check("irq_clear", 32'(irq), 32'h0000_0000);
      $display("test row %0d done", i);
    end
    run('{6'h03, 32'h0000_0044, 2'h2, 8'h80, RES_TIMEOUT, 1'h1});
    check("caps_abort", 32'(rd[7:0]), 32'(RES_TIMEOUT));
    mode <= 2'h0;
    n0 = n_req;
    repeat (500) @(posedge hclk);
    check("auto_rdo", last_rdo, auto_rdo);
    check("auto_count", 32'(n_req - n0), 32'h0000_0001);
    ahb(1'b0, ADDR_ACT_RDO, 32'h0000_0000);
    check("auto_act", rd, auto_rdo);
    check("auto_irq", 32'(irq), 32'h0000_0001);
    $display("test auto request done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, ADDR_SINK_REQ, 32'h0000_0000);
    check("rst_sink_req", rd, 32'h0000_0000);
    check("rst_irq", 32'(irq), 32'h0000_0000);
    $display("test second reset done");
    print_verdict;
  end
endmodule // tb
`default_nettype wire
